// File: rtl/dcsp_core.sv
// Dual channel stamp processor: sample intake, stamp forming, divider, result buffer.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module dcsp_core (
	// Clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [dcsp_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Raw sample stream
	input  wire logic                        in_valid,
	output logic                             in_ready,
	input  wire logic [dcsp_pkg::EVT_W-1:0]  in_event,
	input  wire logic [dcsp_pkg::TIME_W-1:0] in_time,
	input  wire logic [dcsp_pkg::INT_W-1:0]  in_interp,
	input  wire logic                        in_block,
	input  wire logic                        in_suppr,
	// Result stream
	output logic                             out_valid,
	input  wire logic                        out_ready,
	output logic      [dcsp_pkg::RES_W-1:0]  out_result,
	output logic      [dcsp_pkg::RES_W-1:0]  out_result_b,
	output logic      [dcsp_pkg::TS_W-1:0]   out_gate_a,
	output logic      [dcsp_pkg::TS_W-1:0]   out_gate_b,
	output logic                             out_block
);
	import dcsp_pkg::*;

	localparam int REC_W = 2 * RES_W + 2 * TS_W + 1;
	localparam int DC_W  = $clog2(DIV_W + 1);

	typedef enum logic [2:0] {S_IDLE, S_DIV_A, S_DIV_B, S_DIV_R, S_PUSH} dcsp_state_e;

	dcsp_state_e              st_q;
	logic [CTRL_W-1:0]        ctrl_q;
	logic [31:0]              evt_ovf_q;
	logic [31:0]              tim_ovf_q;
	logic [31:0]              offset_q;
	logic [31:0]              count_q;
	logic [31:0]              prdata_q;
	logic                     pslverr_q;
	logic                     phase_q;
	logic                     hist_q;
	logic                     supp_q;
	logic                     blk_q;
	logic [EVT_W-1:0]         ea_raw_q;
	logic [EVT_W-1:0]         eb_raw_q;
	logic [TIME_W-1:0]        t_raw_q;
	logic [TS_W-1:0]          ea_acc_q;
	logic [TS_W-1:0]          eb_acc_q;
	logic [TS_W-1:0]          t_acc_q;
	logic [TS_W-1:0]          ea_q;
	logic [TS_W-1:0]          ea_p_q;
	logic [TS_W-1:0]          eb_q;
	logic [TS_W-1:0]          eb_p_q;
	logic [TS_W-1:0]          ta_q;
	logic [TS_W-1:0]          ta_p_q;
	logic [TS_W-1:0]          tb_q;
	logic [TS_W-1:0]          tb_p_q;
	logic [RES_W-1:0]         res_a_q;
	logic [RES_W-1:0]         res_b_q;
	logic [RES_W-1:0]         res_r_q;
	logic [DIV_W-1:0]         num_q;
	logic [DIV_W-1:0]         den_q;
	logic [DIV_W-1:0]         rem_q;
	logic [DIV_W-1:0]         quo_q;
	logic [DC_W-1:0]          dcnt_q;
	logic                     run_q;
	logic [REC_W-1:0]         mem_q [2];
	logic                     wp_q;
	logic                     rp_q;
	logic [1:0]               bcnt_q;

	// ==========================================================
	// APB register file
	// Read data is captured in the setup cycle so that it comes from a flip-flop
	// and the slave still answers without wait states.
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_q <= 1'b0;
			case (paddr)
				REG_CTRL:    prdata_q <= 32'(ctrl_q);
				REG_EVT_OVF: prdata_q <= evt_ovf_q;
				REG_TIM_OVF: prdata_q <= tim_ovf_q;
				REG_OFFSET:  prdata_q <= offset_q;
				REG_STATUS: begin
					prdata_q  <= 32'({bcnt_q, phase_q, hist_q, st_q != S_IDLE});
					pslverr_q <= pwrite;
				end
				REG_COUNT: begin
					prdata_q  <= count_q;
					pslverr_q <= pwrite;
				end
				default: begin
					prdata_q  <= 32'h0000_0000;
					pslverr_q <= 1'b1;
				end
			endcase
		end
	end

	// The correction values are not shadowed; changing them mid-block corrupts stamps.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= CTRL_RST;
			evt_ovf_q <= OVF_RST;
			tim_ovf_q <= OVF_RST;
			offset_q  <= OFF_RST;
		end else if (psel && penable && pwrite) begin
			case (paddr)
				REG_CTRL:    ctrl_q    <= pwdata[CTRL_W-1:0];
				REG_EVT_OVF: evt_ovf_q <= pwdata;
				REG_TIM_OVF: tim_ovf_q <= pwdata;
				REG_OFFSET:  offset_q  <= pwdata;
				default:     ;
			endcase
		end
	end

	// ==========================================================
	// Sample intake and stamp forming
	logic             fire;
	logic             is_stop;
	logic             pre;
	logic [TS_W-1:0]  ea_acc_n;
	logic [TS_W-1:0]  eb_acc_n;
	logic [TS_W-1:0]  t_acc_n;
	logic [TS_W-1:0]  ecorr_w;
	logic [TS_W-1:0]  estamp_w;
	logic [TS_W-1:0]  tcorr_w;
	logic [TS_W-1:0]  ts_w;
	logic [TS_W-1:0]  off_ext;

	assign in_ready = (st_q == S_IDLE);
	assign fire     = in_valid && in_ready;
	assign is_stop  = phase_q && !in_block;
	assign ea_acc_n = ea_acc_q + ((in_event < ea_raw_q) ? TS_W'(evt_ovf_q) : '0);
	assign eb_acc_n = eb_acc_q + ((in_event < eb_raw_q) ? TS_W'(evt_ovf_q) : '0);
	assign ecorr_w  = TS_W'(in_event) + (is_stop ? eb_acc_n : ea_acc_n);
	assign pre      = is_stop ? ctrl_q[CTRL_PRE_B] : ctrl_q[CTRL_PRE_A];
	assign estamp_w = pre ? (ecorr_w << PRE_SH) : ecorr_w;
	assign t_acc_n  = t_acc_q + ((in_time < t_raw_q) ? TS_W'(tim_ovf_q) : '0);
	assign tcorr_w  = TS_W'(in_time) + t_acc_n;
	assign ts_w     = TS_W'(tcorr_w * TS_W'(TS_MUL)) - TS_W'(in_interp);
	assign off_ext  = {{(TS_W - 32){offset_q[31]}}, offset_q};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q  <= 1'b0;
			t_raw_q  <= '0;
			t_acc_q  <= '0;
			ea_raw_q <= '0;
			ea_acc_q <= '0;
			ea_q     <= '0;
			ea_p_q   <= '0;
			ta_q     <= '0;
			ta_p_q   <= '0;
			eb_raw_q <= '0;
			eb_acc_q <= '0;
			eb_q     <= '0;
			eb_p_q   <= '0;
			tb_q     <= '0;
			tb_p_q   <= '0;
		end else if (fire) begin
			phase_q <= !is_stop;
			t_raw_q <= in_time;
			t_acc_q <= t_acc_n;
			if (is_stop) begin
				eb_raw_q <= in_event;
				eb_acc_q <= eb_acc_n;
				eb_p_q   <= eb_q;
				eb_q     <= estamp_w;
				tb_p_q   <= tb_q;
				tb_q     <= ts_w + off_ext;
			end else begin
				ea_raw_q <= in_event;
				ea_acc_q <= ea_acc_n;
				ea_p_q   <= ea_q;
				ea_q     <= estamp_w;
				ta_p_q   <= ta_q;
				ta_q     <= ts_w;
			end
		end
	end

	// A suppressed pair or a new block breaks the history, so no result spans it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist_q <= 1'b0;
			supp_q <= 1'b0;
			blk_q  <= 1'b0;
		end else if (fire) begin
			if (is_stop) begin
				hist_q <= !(supp_q || in_suppr);
			end else begin
				supp_q <= in_suppr;
				blk_q  <= in_block;
				if (in_block) begin
					hist_q <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Sequential divider, one quotient bit per cycle
	logic [TS_W-1:0]  de_a;
	logic [TS_W-1:0]  dt_a;
	logic [TS_W-1:0]  de_b;
	logic [TS_W-1:0]  dt_b;
	logic [TS_W-1:0]  op_num;
	logic [TS_W-1:0]  op_den;
	logic [DIV_W:0]   rem_sh;
	logic             ge;
	logic             div_done;
	logic [RES_W-1:0] div_res;
	logic             per;

	assign per      = ctrl_q[CTRL_PERIOD];
	assign de_a     = ea_q - ea_p_q;
	assign dt_a     = ta_q - ta_p_q;
	assign de_b     = eb_q - eb_p_q;
	assign dt_b     = tb_q - tb_p_q;
	assign rem_sh   = {rem_q, num_q[DIV_W-1]};
	assign ge       = rem_sh >= {1'b0, den_q};
	assign div_done = run_q && (dcnt_q == '0);
	assign div_res  = ((den_q == '0) || (|quo_q[DIV_W-1:RES_W])) ? '1 : quo_q[RES_W-1:0];

	always_comb begin
		op_num = per ? dt_a : de_a;
		op_den = per ? de_a : dt_a;
		if (st_q == S_DIV_B) begin
			op_num = per ? dt_b : de_b;
			op_den = per ? de_b : dt_b;
		end else if (st_q == S_DIV_R) begin
			op_num = TS_W'(res_a_q);
			op_den = TS_W'(res_b_q);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			num_q  <= '0;
			den_q  <= '0;
			rem_q  <= '0;
			quo_q  <= '0;
			dcnt_q <= '0;
			run_q  <= 1'b0;
		end else if (st_q inside {S_DIV_A, S_DIV_B, S_DIV_R} && !run_q) begin
			num_q  <= {op_num, {FRAC_W{1'b0}}};
			den_q  <= DIV_W'(op_den);
			rem_q  <= '0;
			quo_q  <= '0;
			dcnt_q <= DC_W'(DIV_W);
			run_q  <= 1'b1;
		end else if (run_q && dcnt_q != '0) begin
			rem_q  <= ge ? DIV_W'(rem_sh - {1'b0, den_q}) : DIV_W'(rem_sh);
			quo_q  <= {quo_q[DIV_W-2:0], ge};
			num_q  <= {num_q[DIV_W-2:0], 1'b0};
			dcnt_q <= dcnt_q - 1'b1;
		end else begin
			run_q  <= 1'b0;
		end
	end

	// ==========================================================
	// Measurement sequencing and result combination
	logic [RES_W-1:0] combo_w;
	logic [TS_W-1:0]  gate_a_w;
	logic [TS_W-1:0]  gate_b_w;
	logic [REC_W-1:0] rec_w;
	logic             buf_rdy;
	dcsp_op_e         op;

	assign op       = dcsp_op_e'(ctrl_q[CTRL_OP_HI:CTRL_OP_LO]);
	assign gate_a_w = ctrl_q[CTRL_EXP] ? dt_a : '0;
	assign gate_b_w = ctrl_q[CTRL_EXP] ? dt_b : '0;
	assign rec_w    = {combo_w, res_b_q, gate_a_w, gate_b_w, blk_q};
	assign buf_rdy  = (bcnt_q != 2'h2);

	always_comb begin
		unique case (op)
			DCSP_OP_DUAL:  combo_w = res_a_q;
			DCSP_OP_RATIO: combo_w = res_r_q;
			DCSP_OP_SUM:   combo_w = res_a_q + res_b_q;
			DCSP_OP_DIFF:  combo_w = res_b_q - res_a_q;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q    <= S_IDLE;
			res_a_q <= '0;
			res_b_q <= '0;
			res_r_q <= '0;
			count_q <= 32'h0000_0000;
		end else begin
			unique case (st_q)
				S_IDLE: begin
					if (fire && is_stop && hist_q && !(supp_q || in_suppr)) begin
						st_q <= S_DIV_A;
					end
				end
				S_DIV_A: begin
					if (div_done) begin
						res_a_q <= div_res;
						st_q    <= S_DIV_B;
					end
				end
				S_DIV_B: begin
					if (div_done) begin
						res_b_q <= div_res;
						st_q    <= (op == DCSP_OP_RATIO) ? S_DIV_R : S_PUSH;
					end
				end
				S_DIV_R: begin
					if (div_done) begin
						res_r_q <= div_res;
						st_q    <= S_PUSH;
					end
				end
				S_PUSH: begin
					if (buf_rdy) begin
						count_q <= count_q + 32'h0000_0001;
						st_q    <= S_IDLE;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Two-entry result buffer
	logic push;
	logic pop;

	assign push      = (st_q == S_PUSH) && buf_rdy;
	assign pop       = out_valid && out_ready;
	assign out_valid = (bcnt_q != 2'h0);
	assign {out_result, out_result_b, out_gate_a, out_gate_b, out_block} = mem_q[rp_q];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				mem_q[i] <= '0;
			end
			wp_q   <= 1'b0;
			rp_q   <= 1'b0;
			bcnt_q <= 2'h0;
		end else begin
			if (push) begin
				mem_q[wp_q] <= rec_w;
				wp_q        <= !wp_q;
			end
			if (pop) begin
				rp_q <= !rp_q;
			end
			bcnt_q <= bcnt_q + 2'(push) - 2'(pop);
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_start_fire;
		fire && !is_stop;
	endsequence
	sequence s_stop_fire;
		fire && is_stop;
	endsequence

	property p_pair;
		s_start_fire |=> phase_q;
	endproperty
	a_pair: assert property (p_pair) else $error("start sample not followed by stop slot");

	property p_pair_end;
		s_stop_fire |=> !phase_q;
	endproperty
	a_pair_end: assert property (p_pair_end) else $error("stop sample did not close pair");

	property p_supp;
		s_stop_fire ##0 (in_suppr || supp_q) |=> st_q == S_IDLE && !hist_q;
	endproperty
	a_supp: assert property (p_supp) else $error("suppressed pair produced work");

	property p_evt_a;
		s_start_fire ##0 (in_event < ea_raw_q) |=>
			ea_acc_q == $past(ea_acc_q) + TS_W'($past(evt_ovf_q));
	endproperty
	a_evt_a: assert property (p_evt_a) else $error("start rollover not corrected");

	property p_evt_b;
		s_stop_fire ##0 (in_event < eb_raw_q) |=>
			eb_acc_q == $past(eb_acc_q) + TS_W'($past(evt_ovf_q));
	endproperty
	a_evt_b: assert property (p_evt_b) else $error("stop rollover not corrected");

	property p_pre;
		s_start_fire ##0 ctrl_q[CTRL_PRE_A] |=> ea_q == TS_W'($past(ecorr_w) << PRE_SH);
	endproperty
	a_pre: assert property (p_pre) else $error("prescaled event not scaled by four");

	property p_time;
		fire && (in_time < t_raw_q) |=> t_acc_q == $past(t_acc_q) + TS_W'($past(tim_ovf_q));
	endproperty
	a_time: assert property (p_time) else $error("time rollover not corrected");

	property p_stamp;
		s_start_fire |=> ta_q == TS_W'($past(tcorr_w) * TS_W'(TS_MUL)) - TS_W'($past(in_interp));
	endproperty
	a_stamp: assert property (p_stamp) else $error("start stamp wrong");

	property p_offs;
		s_stop_fire |=> tb_q - off_ext == $past(ts_w);
	endproperty
	a_offs: assert property (p_offs) else $error("stop stamp offset wrong");

	property p_only;
		s_start_fire |=> $stable(eb_q) && $stable(tb_q);
	endproperty
	a_only: assert property (p_only) else $error("start sample touched stop stamps");

	property p_gate;
		push && !ctrl_q[CTRL_EXP] |=> ##[0:1] (mem_q[$past(wp_q)][2*TS_W:1] == '0);
	endproperty
	a_gate: assert property (p_gate) else $error("gate time output while disabled");
endmodule

// File: rtl/dcsp_pkg.sv
// Constants and types shared by the dual channel stamp processor.
package dcsp_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam int unsigned   APB_AW      = 8;
	localparam logic [7:0]    REG_CTRL    = 8'h00;
	localparam logic [7:0]    REG_EVT_OVF = 8'h04;
	localparam logic [7:0]    REG_TIM_OVF = 8'h08;
	localparam logic [7:0]    REG_OFFSET  = 8'h0c;
	localparam logic [7:0]    REG_STATUS  = 8'h10;
	localparam logic [7:0]    REG_COUNT   = 8'h14;
	// ==========================================================
	// Control field layout and reset values
	localparam int            CTRL_W      = 6;
	localparam int            CTRL_PERIOD = 0;
	localparam int            CTRL_OP_LO  = 1;
	localparam int            CTRL_OP_HI  = 2;
	localparam int            CTRL_EXP    = 3;
	localparam int            CTRL_PRE_A  = 4;
	localparam int            CTRL_PRE_B  = 5;
	localparam logic [5:0]    CTRL_RST    = 6'h00;
	localparam logic [31:0]   OVF_RST     = 32'h0000_0000;
	localparam logic [31:0]   OFF_RST     = 32'h0000_0000;
	// ==========================================================
	// Datapath widths
	localparam int            EVT_W       = 32;
	localparam int            TIME_W      = 32;
	localparam int            INT_W       = 16;
	localparam int            TS_W        = 48;
	localparam int            RES_W       = 32;
	localparam int            FRAC_W      = 16;
	localparam int            DIV_W       = TS_W + FRAC_W;
	// ==========================================================
	// Stamp scaling: coarse tick 2 ns, interpolator step 0.1 ns
	localparam int            TIME_LSB_PS = 2000;
	localparam int            INT_LSB_PS  = 100;
	localparam int            TS_MUL      = TIME_LSB_PS / INT_LSB_PS;
	localparam int            PRE_SH      = 2;
	// ==========================================================
	// Two-channel combination
	typedef enum logic [1:0] {
		DCSP_OP_DUAL,
		DCSP_OP_RATIO,
		DCSP_OP_SUM,
		DCSP_OP_DIFF
	} dcsp_op_e;
endpackage

// File: tb/dcsp_src.sv
// Sample source standing in for the counting hardware.
`timescale 1ns/1ps
module dcsp_src (
	// Clock
	input  wire logic        pclk,
	// Raw sample stream
	output logic             in_valid,
	input  wire logic        in_ready,
	output logic [31:0]      in_event,
	output logic [31:0]      in_time,
	output logic [15:0]      in_interp,
	output logic             in_block,
	output logic             in_suppr
);
	initial begin
		in_valid = 0;
		in_event = 0;
		in_time = 0;
		in_interp = 0;
		in_block = 0;
		in_suppr = 0;
	end
	// =====
	// One sample, held until taken. Released lines show the inverse value.
	task automatic send(input logic [31:0] e, t, input logic [15:0] i,
		input bit b, s, input int gap);
		repeat (gap) @(posedge pclk);
		in_valid <= 1;
		in_event <= e;
		in_time <= t;
		in_interp <= i;
		in_block <= b;
		in_suppr <= s;
		do begin
			@(posedge pclk);
		end while (in_ready !== 1'b1);
		in_valid <= 0;
		in_event <= ~e;
		in_time <= ~t;
		in_interp <= ~i;
		in_block <= ~b;
		in_suppr <= ~s;
		@(posedge pclk);
	endtask
	task automatic pair(input logic [31:0] ea, ta, input logic [15:0] ia,
		input logic [31:0] eb, tz, input logic [15:0] ib, input bit b, s, input int gap);
		send(ea, ta, ia, b, s, gap);
		send(eb, tz, ib, 0, 0, 0);
	endtask
endmodule

// File: tb/tb_dcsp_core.sv
// Self-checking bench for the dual channel stamp processor.
`timescale 1ns/1ps
module tb_dcsp_core;
	import dcsp_pkg::*;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]    paddr;
	logic [31:0]   pwdata, prdata, out_result, out_result_b;
	logic          in_valid, in_ready, in_block, in_suppr, out_valid, out_ready, out_block;
	logic [31:0]   in_event, in_time;
	logic [15:0]   in_interp;
	logic [47:0]   out_gate_a, out_gate_b;
	logic [31:0]   evt_ovf = 0, tim_ovf = 0, offset = 0, rs_a = 0, rs_b = 0, rt = 0;
	logic [63:0]   ac_a = 0, ac_b = 0, ac_t = 0, pe_a, pe_b, ps_a, ps_b;
	logic [5:0]    ctrl = 0;
	logic [159:0]  exp_q[$], sb_e;
	bit            hist = 0;
	int            err_count = 0, comparisons = 0, n = 0;

	dcsp_core i_dcsp_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .in_valid, .in_ready, .in_event, .in_time,
		.in_interp, .in_block, .in_suppr, .out_valid, .out_ready, .out_result,
		.out_result_b, .out_gate_a, .out_gate_b, .out_block);
	dcsp_src i_dcsp_src (.pclk, .in_valid, .in_ready, .in_event, .in_time,
		.in_interp, .in_block, .in_suppr);

	always #50 pclk = ~pclk;
	// =====
	// Checking
	task automatic chk(input logic [63:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		if (presetn && out_valid && out_ready) begin
			if (exp_q.size() == 0) chk(1, 0);
			else begin
				sb_e = exp_q.pop_front();
				chk(out_result, sb_e[159:128]);
				chk(out_result_b, sb_e[127:96]);
				chk(out_gate_a, sb_e[95:48]);
				chk(out_gate_b, sb_e[47:0]);
				chk(out_block, 0);
			end
		end
	end
	// Waits for every expected record, then a spell longer than one divide.
	task automatic settle();
		int k;
		k = 0;
		while (exp_q.size() != 0 && k < 3000) begin
			@(posedge pclk);
			k++;
		end
		repeat (250) @(posedge pclk);
		chk(exp_q.size(), 0);
	endtask
	// =====
	// Register bus
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(0, a, 0, r, e);
		chk(r, x);
		chk(e, xe);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1, a, d, r, e);
		chk(e, 0);
	endtask
	task automatic cfg(input logic [5:0] c);
		ctrl = c;
		wr(REG_CTRL, {26'h0, c});
	endtask
	// =====
	// Reference model of one measurement, then the pair is sent
	function automatic logic [31:0] qd(input logic [63:0] a, d);
		logic [63:0] q;
		if (d == 0) return 32'hffff_ffff;
		q = (a << 16) / d;
		return (q[63:32] != 0) ? 32'hffff_ffff : q[31:0];
	endfunction
	task automatic meas(input logic [31:0] ea, ta, eb, tz, input bit blk, sup);
		logic [63:0] ca, cb, sa, sb, xa, xb, r, ga, gb;
		logic [15:0] ia, ib;
		ia = {12'h0, n[3:0]};
		ib = {13'h0, n[2:0]};
		if (ea < rs_a) ac_a += evt_ovf;
		if (eb < rs_b) ac_b += evt_ovf;
		if (ta < rt) ac_t += tim_ovf;
		sa = (ta + ac_t) * TS_MUL - ia;
		if (tz < ta) ac_t += tim_ovf;
		sb = (tz + ac_t) * TS_MUL - ib + {{32{offset[31]}}, offset};
		ca = ({32'h0, ea} + ac_a) << (ctrl[CTRL_PRE_A] ? 2 : 0);
		cb = ({32'h0, eb} + ac_b) << (ctrl[CTRL_PRE_B] ? 2 : 0);
		if (hist && !blk && !sup) begin
			xa = ctrl[0] ? qd(sa - ps_a, ca - pe_a) : qd(ca - pe_a, sa - ps_a);
			xb = ctrl[0] ? qd(sb - ps_b, cb - pe_b) : qd(cb - pe_b, sb - ps_b);
			case (ctrl[2:1])
				2'h0: r = xa;
				2'h1: r = qd(xa, xb);
				2'h2: r = xa + xb;
				default: r = xb - xa;
			endcase
			ga = ctrl[3] ? sa - ps_a : 0;
			gb = ctrl[3] ? sb - ps_b : 0;
			exp_q.push_back({r[31:0], xb[31:0], ga[47:0], gb[47:0]});
		end
		hist = !sup;
		{rs_a, rs_b, rt} = {ea, eb, tz};
		{pe_a, pe_b, ps_a, ps_b} = {ca, cb, sa, sb};
		i_dcsp_src.pair(ea, ta, ia, eb, tz, ib, blk, sup, n % 3);
		n++;
	endtask
	task automatic go(input bit blk, sup);
		meas(100 + 37 * n, 9000 + 900 * n, 200 + 23 * n, 9400 + 900 * n, blk, sup);
	endtask
	// =====
	// Scenarios
	task automatic s_regs();
		rd(REG_CTRL, 0, 0);
		rd(REG_EVT_OVF, 0, 0);
		rd(REG_TIM_OVF, 0, 0);
		rd(REG_OFFSET, 0, 0);
		rd(REG_STATUS, 0, 0);
		rd(REG_COUNT, 0, 0);
		rd(8'h18, 0, 1);
		rd(REG_STATUS, 0, 0);
	endtask
	task automatic s_dual();
		evt_ovf = 32'h1000;
		tim_ovf = 32'h1_0000;
		offset = 32'hffff_fffb;
		wr(REG_EVT_OVF, evt_ovf);
		wr(REG_TIM_OVF, tim_ovf);
		wr(REG_OFFSET, offset);
		rd(REG_OFFSET, offset, 0);
		cfg(6'h08);
		meas(100, 1000, 300, 1400, 1, 0);
		meas(150, 2000, 330, 2400, 0, 0);
		meas(200, 3000, 20, 3400, 0, 0);
		meas(40, 4000, 50, 4400, 0, 0);
		meas(90, 300, 80, 200, 0, 0);
		settle();
	endtask
	task automatic s_ops();
		for (int op = 0; op < 4; op++) begin
			cfg({op[0], op[0], 1'b0, op[1:0], 1'b1});
			go(1, 0);
			go(0, 0);
			settle();
		end
	endtask
	task automatic s_supp();
		logic [31:0] c0;
		logic        e;
		cfg(6'h08);
		apb(0, REG_COUNT, 0, c0, e);
		go(1, 0);
		go(0, 0);
		go(0, 1);
		go(0, 0);
		go(0, 0);
		settle();
		rd(REG_COUNT, c0 + 2, 0);
	endtask
	// Receiver stalls: two records wait in the buffer, the third holds intake.
	task automatic s_stall();
		logic [31:0] r;
		logic        e;
		out_ready <= 0;
		fork
			begin
				go(1, 0);
				go(0, 0);
				go(0, 0);
				go(0, 0);
			end
			begin
				repeat (900) @(posedge pclk);
				apb(0, REG_STATUS, 0, r, e);
				chk(r[4:3], 2);
				chk(in_ready, 0);
				chk(out_valid, 1);
				out_ready <= 1;
			end
		join
		settle();
	endtask
	// =====
	// Main sequence and watchdog
	initial begin
		pclk = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		out_ready = 1;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		s_regs();
		s_dual();
		s_ops();
		s_supp();
		s_stall();
		print_verdict();
	end
	initial begin
		#(40000 * 100);
		err_count++;
		print_verdict();
	end
endmodule
